// [inc/vts_pkg.sv]
package vts_pkg;

   // timing of the slew clock derived from the 100 MHz system clock
   localparam int CLK_PERIOD_NS   = 10;
   localparam int SLEW_MIN_NS     = 1000;
   localparam int SLEW_MAX_NS     = 10000;
   localparam int SLEW_MIN_CYC    = (SLEW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SLEW_MAX_CYC    = SLEW_MAX_NS / CLK_PERIOD_NS;
   localparam int SLEW_CNT_W      = 10;
   localparam logic [9:0] SLEW_MIN_CYC_W = 10'(SLEW_MIN_CYC);
   localparam logic [9:0] SLEW_MAX_CYC_W = 10'(SLEW_MAX_CYC);

   // blanking and falling-edge synchronisation, counted in slew ticks
   localparam logic [4:0] BLANK_TICKS     = 5'h18;
   localparam logic [1:0] FALL_SYNC_TICKS = 2'h2;

   // reference held in 25 mV units, 0 is the 0 V code
   localparam int         REF_W          = 7;
   localparam logic [6:0] REF_ZERO       = 7'h00;
   localparam logic [6:0] MOB_COARSE_TOP = 7'h46;
   localparam logic [6:0] MOB_FINE_TOP   = 7'h27;
   localparam logic [6:0] DESK_TOP       = 7'h4a;
   localparam logic [6:0] SUS_LOW_BASE   = 7'h1b;
   localparam logic [6:0] SUS_UP_BASE    = 7'h2b;
   localparam logic [4:0] VID_OFF_CODE   = 5'h1f;

   // multi-level pin encodings
   localparam logic [1:0] LVL_LOW  = 2'h0;
   localparam logic [1:0] LVL_MID  = 2'h1;
   localparam logic [1:0] LVL_HIGH = 2'h2;

   typedef enum logic [2:0] {
      ST_RAMP       = 3'b000,
      ST_SETTLE     = 3'b001,
      ST_REGULATE   = 3'b010,
      ST_FAULT_DOWN = 3'b011,
      ST_FAULT_HOLD = 3'b100
   } vts_state_t;

   // voltage-ident code to reference units
   function automatic logic [6:0] vid_target(input logic mobile, input logic [4:0] code);
      logic [6:0] res;
      res = REF_ZERO;
      if (mobile)
      begin
         if (code[4])
            res = MOB_FINE_TOP - {3'h0, code[3:0]};
         else
            res = MOB_COARSE_TOP - {2'h0, code[3:0], 1'b0};
      end
      else if (code != VID_OFF_CODE)
      begin
         res = DESK_TOP - {2'h0, code};
      end
      return res;
   endfunction

   // suspend pins {upper pin, lower pin}, each four-level, give 16 steps
   function automatic logic [6:0] sus_target(input logic upper, input logic [3:0] pins);
      logic [6:0] base;
      base = upper ? SUS_UP_BASE : SUS_LOW_BASE;
      return base + {3'h0, pins};
   endfunction

endpackage

// [src/vts_core.sv]
`timescale 1ns/100ps
// Summary of operation
// RL1: suspend select mid or high disables offset and targets the suspend code
// RL2: suspend transition blanks power-good and faults until 24 ticks after arrival
// RL3: suspend select mid picks upper range, high picks lower, low is normal
// RL4: power-good is frozen from the start of every transition
// RL5: power-good is re-enabled 24 slew ticks after the final code
// RL6: reference moves exactly one 25 mV code per slew tick
// RL7: falling transitions wait two extra ticks before stepping
// RL8: slew period is programmable between 1.0 us and 10 us
// RL9: forced-PWM mode trips overvoltage above target plus 13 percent
// RL10: pulse-skip mode trips overvoltage only above the fixed 2 V level
// RL11: overvoltage sets the fault latch, drops power-good, starts shutdown
// RL12: fault latch holds until shutdown is toggled or supply collapses
// RL13: overvoltage blanked during transitions and 24 ticks afterwards
// RL14: output below 70 percent sets the fault latch and starts shutdown
// RL15: after fault ramp reaches zero, low side forced high, high side low
// RL16: mobile table maps codes 1.750 V down to 0.600 V
// RL17: suspend pins decode 0.675-1.050 V or 1.075-1.450 V in 25 mV steps
// RL18: outside party ties the table select high for mobile, low for desktop
// RL19: undervoltage blanked during transitions and 24 ticks afterwards
// RL20: on power-up the reference climbs from zero to the target
// RL21: comparator flags are synchronised and sampled on the slew tick
module vts_core
(
   // clock and reset; reset is the shutdown input combined with supply good
   input  wire logic       clk_sys_in,
   input  wire logic       rst_n_in,
   // processor code and mode inputs
   input  wire logic [4:0] voltage_code_bits_in,
   input  wire logic       table_mobile_in,
   input  wire logic [1:0] suspend_select_in,
   input  wire logic [3:0] suspend_code_pins_in,
   input  wire logic [1:0] skip_select_in,
   input  wire logic       no_fault_mode_in,
   // slew timing, equivalent of the timing resistor
   input  wire logic [9:0] slew_period_cyc_in,
   // comparator flags
   input  wire logic       overvoltage_pct_in,
   input  wire logic       overvoltage_fixed_in,
   input  wire logic       undervoltage_trip_in,
   // gate requests from the on-time logic
   input  wire logic       pwm_high_req_in,
   input  wire logic       pwm_low_req_in,
   // reference and status
   output logic [6:0]      ref_code_out,
   output logic            power_good_out,
   output logic            fault_latched_out,
   output logic            offset_enable_out,
   output logic            transition_active_out,
   // gate drives
   output logic            high_side_drive_out,
   output logic            low_side_drive_out
);

   logic                rst_meta_ff;
   logic                rst_n_ff;
   logic                tick;
   vts_pkg::vts_state_t state_ff;
   vts_pkg::vts_state_t nxt_state;
   logic [6:0]          ref_ff;
   logic [6:0]          nxt_ref;
   logic [1:0]          fall_wait_ff;
   logic [1:0]          nxt_fall_wait;
   logic [4:0]          settle_ff;
   logic [4:0]          nxt_settle;
   logic                pg_ff;
   logic                nxt_pg;
   logic                fault_ff;
   logic                nxt_fault;
   logic                offset_ff;
   logic                hi_ff;
   logic                lo_ff;
   logic [2:0]          flag_meta_ff;
   logic [2:0]          flag_sync_ff;
   logic                ov_samp_ff;
   logic                uv_samp_ff;
   logic [5:0]          since_arrive_ff;

   // synchronous release of the asynchronous reset
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rst_meta_ff <= 1'b0;
         rst_n_ff    <= 1'b0;
      end
      else
      begin
         rst_meta_ff <= 1'b1;
         rst_n_ff    <= rst_meta_ff;
      end
   end

   vts_slew_tick u_tick
   (
      .clk_sys_in    (clk_sys_in),
      .rst_n_in      (rst_n_ff),
      .period_cyc_in (slew_period_cyc_in),
      .tick_out      (tick)
   );

   // target selection
   wire       sus_active = (suspend_select_in != vts_pkg::LVL_LOW); // see RL1
   wire       sus_upper  = (suspend_select_in == vts_pkg::LVL_MID); // see RL3
   wire [6:0] vid_tgt    = vts_pkg::vid_target(table_mobile_in, voltage_code_bits_in); // see RL16
   wire [6:0] sus_tgt    = vts_pkg::sus_target(sus_upper, suspend_code_pins_in); // see RL17
   wire       in_fault   = (state_ff == vts_pkg::ST_FAULT_DOWN) ||
                           (state_ff == vts_pkg::ST_FAULT_HOLD);
   wire [6:0] target     = in_fault ? vts_pkg::REF_ZERO :
                           (sus_active ? sus_tgt : vid_tgt); // see RL1

   // stepping decisions
   wire       going_up   = (ref_ff < target);
   wire       going_down = (ref_ff > target);
   wire       at_target  = (ref_ff == target);
   wire       fall_ready = (fall_wait_ff == vts_pkg::FALL_SYNC_TICKS); // see RL7
   wire       step_up    = tick && going_up; // see RL6
   wire       step_down  = tick && going_down && fall_ready; // see RL6

   // comparator path: two-flop synchroniser then a sample on each tick
   always_ff @(posedge clk_sys_in or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         flag_meta_ff <= 3'h0;
         flag_sync_ff <= 3'h0;
      end
      else
      begin
         flag_meta_ff <= {undervoltage_trip_in, overvoltage_fixed_in, overvoltage_pct_in};
         flag_sync_ff <= flag_meta_ff; // see RL21
      end
   end

   // forced PWM compares to the target, pulse skipping to the fixed level
   wire ov_mode_pct = (skip_select_in == vts_pkg::LVL_HIGH);
   wire ov_sel      = ov_mode_pct ? flag_sync_ff[0] : flag_sync_ff[1]; // see RL9 see RL10

   always_ff @(posedge clk_sys_in or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         ov_samp_ff <= 1'b0;
         uv_samp_ff <= 1'b0;
      end
      else if (tick)
      begin
         ov_samp_ff <= ov_sel; // see RL21
         uv_samp_ff <= flag_sync_ff[2];
      end
   end

   // protection only looks at the output once fully settled
   wire prot_open = (state_ff == vts_pkg::ST_REGULATE) && !no_fault_mode_in; // see RL13 see RL19
   wire ov_hit    = prot_open && ov_samp_ff; // see RL11
   wire uv_hit    = prot_open && uv_samp_ff; // see RL14
   wire fault_hit = ov_hit || uv_hit;

   always_comb
   begin
      nxt_state     = state_ff;
      nxt_ref       = ref_ff;
      nxt_fall_wait = fall_wait_ff;
      nxt_settle    = settle_ff;
      if (step_up)
         nxt_ref = ref_ff + 7'h01; // see RL6
      else if (step_down)
         nxt_ref = ref_ff - 7'h01;
      if (!going_down)
         nxt_fall_wait = 2'h0;
      else if (tick && !fall_ready)
         nxt_fall_wait = fall_wait_ff + 2'h1; // see RL7
      case (state_ff)
         vts_pkg::ST_RAMP:
         begin
            nxt_settle = 5'h00;
            if (at_target)
               nxt_state = vts_pkg::ST_SETTLE;
         end
         vts_pkg::ST_SETTLE:
         begin
            if (!at_target)
               nxt_state = vts_pkg::ST_RAMP;
            else if (tick && settle_ff == vts_pkg::BLANK_TICKS - 5'h01)
               nxt_state = vts_pkg::ST_REGULATE; // see RL2 see RL5
            else if (tick)
               nxt_settle = settle_ff + 5'h01;
         end
         vts_pkg::ST_REGULATE:
         begin
            nxt_settle = 5'h00;
            if (fault_hit)
               nxt_state = vts_pkg::ST_FAULT_DOWN; // see RL11 see RL14
            else if (!at_target)
               nxt_state = vts_pkg::ST_RAMP; // see RL4
         end
         vts_pkg::ST_FAULT_DOWN:
         begin
            if (no_fault_mode_in)
               nxt_state = vts_pkg::ST_RAMP;
            else if (ref_ff == vts_pkg::REF_ZERO)
               nxt_state = vts_pkg::ST_FAULT_HOLD; // see RL15
         end
         vts_pkg::ST_FAULT_HOLD:
         begin
            if (no_fault_mode_in)
               nxt_state = vts_pkg::ST_RAMP;
         end
         default:
         begin
            nxt_state = vts_pkg::ST_FAULT_DOWN;
         end
      endcase
   end

   // the latch has no clear path other than reset or the test mode
   assign nxt_fault = no_fault_mode_in ? 1'b0 : (fault_ff || fault_hit); // see RL12
   // power-good changes only while regulating; a fault drops it at once
   assign nxt_pg = fault_hit ? 1'b0 :
                   in_fault ? 1'b0 :
                   (state_ff == vts_pkg::ST_REGULATE) ? !uv_samp_ff : pg_ff; // see RL4 see RL11

   always_ff @(posedge clk_sys_in or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         state_ff     <= vts_pkg::ST_RAMP; // see RL20
         ref_ff       <= vts_pkg::REF_ZERO; // see RL20
         fall_wait_ff <= 2'h0;
         settle_ff    <= 5'h00;
         pg_ff        <= 1'b0;
         fault_ff     <= 1'b0; // see RL12
      end
      else
      begin
         state_ff     <= nxt_state;
         ref_ff       <= nxt_ref;
         fall_wait_ff <= nxt_fall_wait;
         settle_ff    <= nxt_settle;
         pg_ff        <= nxt_pg;
         fault_ff     <= nxt_fault;
      end
   end

   // reset is the shutdown mode: low side on, high side off
   wire force_off = (state_ff == vts_pkg::ST_FAULT_HOLD);

   always_ff @(posedge clk_sys_in or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         offset_ff <= 1'b0;
         hi_ff     <= 1'b0;
         lo_ff     <= 1'b1;
      end
      else
      begin
         offset_ff <= !sus_active; // see RL1
         hi_ff     <= force_off ? 1'b0 : pwm_high_req_in; // see RL15
         lo_ff     <= force_off ? 1'b1 : pwm_low_req_in; // see RL15
      end
   end

   assign ref_code_out          = ref_ff;
   assign power_good_out        = pg_ff;
   assign fault_latched_out     = fault_ff;
   assign offset_enable_out     = offset_ff;
   assign transition_active_out = (state_ff == vts_pkg::ST_RAMP) || (state_ff == vts_pkg::ST_SETTLE);
   assign high_side_drive_out   = hi_ff;
   assign low_side_drive_out    = lo_ff;

   // helper: slew ticks since the reference last arrived at its target
   always_ff @(posedge clk_sys_in or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         since_arrive_ff <= 6'h00;
      else if (state_ff == vts_pkg::ST_RAMP)
         since_arrive_ff <= 6'h00;
      else if (tick && since_arrive_ff != 6'h3f)
         since_arrive_ff <= since_arrive_ff + 6'h01;
   end

   AST_STEP_ONE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_ff) // see RL6
      (ref_ff != $past(ref_ff)) |-> ($past(tick) &&
         ((ref_ff == $past(ref_ff) + 7'h01) || (ref_ff == $past(ref_ff) - 7'h01))))
      else $error("reference moved off a slew tick or by more than one code");

   AST_FALL_WAIT: assert property (@(posedge clk_sys_in) disable iff (!rst_n_ff) // see RL7
      (ref_ff < $past(ref_ff)) |-> ($past(fall_wait_ff) == 2'h2))
      else $error("downward step taken without two synchronising ticks");

   AST_PG_FROZEN: assert property (@(posedge clk_sys_in) disable iff (!rst_n_ff) // see RL4
      (transition_active_out && !fault_hit) |=> (power_good_out == $past(power_good_out)))
      else $error("power-good changed during a transition");

   AST_SETTLE_24: assert property (@(posedge clk_sys_in) disable iff (!rst_n_ff) // see RL5
      $rose(state_ff == vts_pkg::ST_REGULATE) |-> (since_arrive_ff >= 6'h18))
      else $error("regulation resumed before 24 slew ticks");

   AST_BLANK_FAULT: assert property (@(posedge clk_sys_in) disable iff (!rst_n_ff) // see RL13
      (transition_active_out && !fault_ff) |=> !fault_ff)
      else $error("fault latched while protection was blanked");

   AST_SUS_RANGE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_ff) // see RL3
      (!in_fault && suspend_select_in == vts_pkg::LVL_MID) |->
         (target >= 7'h2b && target <= 7'h3a))
      else $error("upper suspend target out of range");

   AST_OFFSET_OFF: assert property (@(posedge clk_sys_in) disable iff (!rst_n_ff) // see RL1
      sus_active [*2] |-> !offset_enable_out)
      else $error("offset still enabled in suspend");

   AST_MOBILE_TOP: assert property (@(posedge clk_sys_in) disable iff (!rst_n_ff) // see RL16
      (!in_fault && !sus_active && table_mobile_in && voltage_code_bits_in == 5'h00) |->
         (target == 7'h46))
      else $error("mobile code zero does not target 1.750 V");

   AST_OV_TRIP: assert property (@(posedge clk_sys_in) disable iff (!rst_n_ff) // see RL11
      ov_hit |=> (fault_latched_out && !power_good_out &&
         state_ff == vts_pkg::ST_FAULT_DOWN))
      else $error("overvoltage did not latch and shut down");

   AST_UV_TRIP: assert property (@(posedge clk_sys_in) disable iff (!rst_n_ff) // see RL14
      uv_hit |=> (fault_latched_out && state_ff == vts_pkg::ST_FAULT_DOWN))
      else $error("undervoltage did not latch and shut down");

   AST_LATCH_HOLD: assert property (@(posedge clk_sys_in) disable iff (!rst_n_ff) // see RL12
      (fault_latched_out && !no_fault_mode_in) |=> fault_latched_out)
      else $error("fault latch cleared without shutdown toggle");

   AST_HOLD_DRIVE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_ff) // see RL15
      (state_ff == vts_pkg::ST_FAULT_HOLD) |=>
         (low_side_drive_out && !high_side_drive_out && ref_code_out == 7'h00))
      else $error("gates not forced after fault ramp-down");

   COV_RISE:  cover property (@(posedge clk_sys_in) disable iff (!rst_n_ff)
      $rose(state_ff == vts_pkg::ST_REGULATE));
   COV_FALL:  cover property (@(posedge clk_sys_in) disable iff (!rst_n_ff)
      step_down);
   COV_SUSP:  cover property (@(posedge clk_sys_in) disable iff (!rst_n_ff)
      sus_active && state_ff == vts_pkg::ST_REGULATE);
   COV_FAULT: cover property (@(posedge clk_sys_in) disable iff (!rst_n_ff)
      state_ff == vts_pkg::ST_FAULT_HOLD);

endmodule

// [src/vts_slew_tick.sv]
`timescale 1ns/100ps
module vts_slew_tick
(
   // clock and reset
   input  wire logic       clk_sys_in,
   input  wire logic       rst_n_in,
   // period set by the timing resistor, in system clocks
   input  wire logic [9:0] period_cyc_in,
   // one-cycle pulse per slew-clock period
   output logic            tick_out
);

   logic [9:0] cnt_ff;
   logic [9:0] nxt_cnt;
   logic [9:0] spacing_ff;
   wire  [9:0] period_clamped;
   wire        wrap;

   // out-of-range settings are clamped rather than rejected
   assign period_clamped = (period_cyc_in < vts_pkg::SLEW_MIN_CYC_W) ? vts_pkg::SLEW_MIN_CYC_W :
                           (period_cyc_in > vts_pkg::SLEW_MAX_CYC_W) ? vts_pkg::SLEW_MAX_CYC_W :
                           period_cyc_in; // see RL8
   assign wrap     = (cnt_ff >= period_clamped - 10'h001);
   assign nxt_cnt  = wrap ? 10'h000 : cnt_ff + 10'h001;
   assign tick_out = wrap;

   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         cnt_ff <= 10'h000;
      else
         cnt_ff <= nxt_cnt;
   end

   // helper: cycles since the previous tick
   always_ff @(posedge clk_sys_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         spacing_ff <= 10'h3ff;
      else if (tick_out)
         spacing_ff <= 10'h000;
      else if (spacing_ff != 10'h3ff)
         spacing_ff <= spacing_ff + 10'h001;
   end

   AST_TICK_SPACING: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // see RL8
      tick_out |-> (spacing_ff >= vts_pkg::SLEW_MIN_CYC_W - 10'h001))
      else $error("slew tick faster than 1.0 us");

endmodule

// [test/voltage_target_slew_fault_seq_bench.sv]
`timescale 1ns/100ps
module voltage_target_slew_fault_seq_bench;
   logic       clk_sys_in = 1'b0;
   logic       rst_n_in   = 1'b0;
   logic       load       = 1'b0;
   logic       mob        = 1'b1;
   logic [9:0] per        = 10'h064;
   logic [4:0] code_c     = 5'h00;
   logic [1:0] sel_c      = 2'h0;
   logic [3:0] pins_c     = 4'h0;
   logic [1:0] skip       = 2'h0;
   logic       ov_pct     = 1'b0;
   logic       ov_fix     = 1'b0;
   logic       uv         = 1'b0;
   logic       req_hi     = 1'b0;
   logic       req_lo     = 1'b0;
   logic [4:0] code_w;
   logic       mob_w;
   logic [1:0] sel_w;
   logic [3:0] pins_w;
   logic [6:0] ref_code;
   logic       pg;
   logic       fault;
   logic       ofs;
   logic       trans;
   logic       hi;
   logic       lo;
   int         errors   = 0;
   int         compares = 0;
   int         cyc      = 0;

   always #5 clk_sys_in = ~clk_sys_in;
   always @(posedge clk_sys_in)
   begin
      cyc    <= cyc + 1;
      req_hi <= 1'($urandom);
      req_lo <= 1'($urandom);
   end

   vts_cpu_model cpu (.clk_sys_in(clk_sys_in), .load_in(load), .mobile_in(mob), .code_in(code_c),
      .sus_sel_in(sel_c), .sus_pins_in(pins_c), .voltage_code_bits_out(code_w),
      .table_mobile_out(mob_w), .suspend_select_out(sel_w), .suspend_code_pins_out(pins_w));

   vts_core dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .voltage_code_bits_in(code_w),
      .table_mobile_in(mob_w), .suspend_select_in(sel_w), .suspend_code_pins_in(pins_w),
      .skip_select_in(skip), .no_fault_mode_in(1'b0), .slew_period_cyc_in(per),
      .overvoltage_pct_in(ov_pct), .overvoltage_fixed_in(ov_fix),
      .undervoltage_trip_in(uv), .pwm_high_req_in(req_hi), .pwm_low_req_in(req_lo),
      .ref_code_out(ref_code), .power_good_out(pg), .fault_latched_out(fault),
      .offset_enable_out(ofs), .transition_active_out(trans),
      .high_side_drive_out(hi), .low_side_drive_out(lo));

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic results();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic bail(input string what);
      errors++;
      $display("Error timeout %s", what);
      results();
   endtask

   // 50 mV steps down from 1.750 V, then 25 mV steps from 0.975 V
   function automatic logic [6:0] mob_ref(input logic [4:0] c);
      return c[4] ? 7'h27 - {3'h0, c[3:0]} : 7'h46 - {2'h0, c[3:0], 1'b0};
   endfunction

   function automatic logic [6:0] sus_ref(input logic [1:0] s, input logic [3:0] p);
      return (s == 2'h1 ? 7'h2b : 7'h1b) + {3'h0, p};
   endfunction

   task automatic cmd(input logic [4:0] c, input logic [1:0] s, input logic [3:0] p);
      @(posedge clk_sys_in);
      code_c <= c;
      sel_c  <= s;
      pins_c <= p;
      load   <= 1'b1;
      @(posedge clk_sys_in);
      load   <= 1'b0;
   endtask

   task automatic reset_pulse();
      @(posedge clk_sys_in);
      rst_n_in <= 1'b0;
      repeat (12) @(posedge clk_sys_in);
      check("reset outputs", {ref_code, hi, lo, pg, fault}, 11'h004);
      rst_n_in <= 1'b1;
   endtask

   // follows a whole transition: step pacing, frozen power-good, blanked faults
   task automatic move(input logic [6:0] tgt);
      int         last;
      int         n;
      logic [6:0] prev;
      logic       pg0;
      logic       fall;
      prev = ref_code;
      pg0  = pg;
      fall = tgt < prev;
      last = cyc;
      n    = 0;
      while (ref_code !== tgt)
      begin
         @(negedge clk_sys_in);
         if (cyc - last > 400)
            bail("step");
         check("pg frozen", pg, pg0);
         check("fault blanked", fault, 1'b0);
         if (ref_code !== prev)
         begin
            if (n == 0)
               check("first step", (cyc - last > (fall ? 200 : 0)) &&
                     (cyc - last <= (fall ? 312 : 110)), 1'b1);
            else
               check("step time", cyc - last, 100);
            check("step", ref_code, fall ? prev - 7'h01 : prev + 7'h01);
            prev = ref_code;
            last = cyc;
            n++;
         end
      end
      n = 0;
      while (trans !== 1'b0)
      begin
         @(negedge clk_sys_in);
         n++;
         check("pg settle", pg, pg0);
         check("fault settle", fault, 1'b0);
         if (n > 2600)
            bail("settle");
      end
      check("settle time", (n >= 2395) && (n <= 2405), 1'b1);
   endtask

   task automatic wait_fault();
      int n;
      n = 0;
      while (fault !== 1'b1)
      begin
         @(negedge clk_sys_in);
         n++;
         if (n > 120)
            bail("fault");
      end
      check("pg on fault", pg, 1'b0);
   endtask

   initial
   begin
      logic [4:0] c;
      logic [4:0] tbl [3];
      int         n;
      tbl = '{5'h0f, 5'h10, 5'h1f};
      void'($urandom(32'h0f141dbc));
      cmd(5'h00, 2'h0, 4'h0);
      reset_pulse();
      move(7'h46);
      repeat (3) @(negedge clk_sys_in);
      check("pg up", pg, 1'b1);
      check("offset on", ofs, 1'b1);
      for (int i = 0; i < 6; i++)
      begin
         c = i < 3 ? tbl[i] : 5'($urandom);
         if (mob_ref(c) === ref_code)
            c = c ^ 5'h01;
         cmd(c, 2'h0, 4'h0);
         move(mob_ref(c));
      end
      // suspend overrides the code; the last pass trips undervoltage after blanking
      for (int s = 1; s < 4; s++)
      begin
         c = 4'($urandom);
         if (sus_ref(2'(s), c[3:0]) === ref_code)
            c = c ^ 5'h01;
         cmd(5'h00, 2'(s), c[3:0]);
         // raised on the edge that loads the new code, a cycle before the core leaves regulation; the synchroniser delay lets blanking hide it
         uv <= (s == 3);
         move(sus_ref(2'(s), c[3:0]));
         check("offset off", ofs, 1'b0);
      end
      wait_fault();
      n = 0;
      while (ref_code !== 7'h00)
      begin
         @(negedge clk_sys_in);
         n++;
         if (n > 9000)
            bail("ramp down");
      end
      repeat (3) @(negedge clk_sys_in);
      for (int i = 0; i < 40; i++)
      begin
         @(negedge clk_sys_in);
         check("gates held", {hi, lo}, 2'b01);
      end
      cmd(5'h1f, 2'h0, 4'h0);
      uv  <= 1'b0;
      per <= 10'h032; // below the 1.0 us floor, so steps stay 100 clocks apart
      repeat (300) @(negedge clk_sys_in);
      check("latch holds", {fault, ref_code}, 8'h80);
      reset_pulse();
      move(7'h18);
      @(posedge clk_sys_in);
      ov_pct <= 1'b1;
      repeat (300) @(negedge clk_sys_in);
      check("pct ignored in skip", fault, 1'b0);
      @(posedge clk_sys_in);
      skip <= 2'h2;
      wait_fault();
      @(posedge clk_sys_in);
      ov_pct <= 1'b0;
      skip   <= 2'h0;
      ov_fix <= 1'b1;
      mob    <= 1'b0; // strap moved only while the core is latched off
      cmd(5'h1e, 2'h0, 4'h0);
      reset_pulse();
      // desktop table, code 11110 is 1.100 V
      move(7'h2c);
      wait_fault();
      results();
   end
endmodule

// [test/vts_cpu_model.sv]
`timescale 1ns/100ps
module vts_cpu_model
(
   // clock
   input  wire logic       clk_sys_in,
   // command from the bench
   input  wire logic       load_in,
   input  wire logic       mobile_in,
   input  wire logic [4:0] code_in,
   input  wire logic [1:0] sus_sel_in,
   input  wire logic [3:0] sus_pins_in,
   // processor pins toward the core
   output logic [4:0]      voltage_code_bits_out,
   output logic            table_mobile_out,
   output logic [1:0]      suspend_select_out,
   output logic [3:0]      suspend_code_pins_out
);
   logic [4:0] code_ff = 5'h00;
   logic [1:0] sel_ff  = 2'h0;
   logic [3:0] pins_ff = 4'h0;
   // board strap, moved by the bench only while the core is held off
   assign table_mobile_out      = mobile_in;
   assign voltage_code_bits_out = code_ff;
   assign suspend_select_out    = sel_ff;
   assign suspend_code_pins_out = pins_ff;
   // every bit moves on one edge so the core never sees a skewed code
   always @(posedge clk_sys_in)
   begin
      if (load_in)
      begin
         code_ff <= code_in;
         sel_ff  <= sus_sel_in;
         pins_ff <= sus_pins_in;
      end
   end
endmodule
